// File: core/pw_gate_pkg.sv
// constants shared by the password access gate and its inactivity timers
// assumes a 10 MHz core clock and 16-bit modbus holding registers
package pw_gate_pkg;
   // ----------------------------------------------------------------
   // register offsets (16-bit register addresses)
   // ----------------------------------------------------------------
   localparam logic [15:0] CMD_PW_HI_ADDR  = 16'h4000;
   localparam logic [15:0] CMD_PW_LO_ADDR  = 16'h4001;
   localparam logic [15:0] SET_PW_HI_ADDR  = 16'h4002;
   localparam logic [15:0] SET_PW_LO_ADDR  = 16'h4003;
   localparam logic [15:0] CMD_ENT_HI_ADDR = 16'h4008;
   localparam logic [15:0] CMD_ENT_LO_ADDR = 16'h4009;
   localparam logic [15:0] SET_ENT_HI_ADDR = 16'h400a;
   localparam logic [15:0] SET_ENT_LO_ADDR = 16'h400b;
   localparam logic [15:0] CMD_STAT_ADDR   = 16'h4010;
   localparam logic [15:0] SET_STAT_ADDR   = 16'h4011;

   // ----------------------------------------------------------------
   // widths, reset values, field positions
   // ----------------------------------------------------------------
   localparam int          REG_W       = 16;
   localparam int          PW_W        = 32;
   localparam logic [31:0] PW_RESET    = 32'h0000_0000;
   localparam logic [31:0] ENC_KEY     = 32'h5a3c_96e1;
   localparam int          STAT_EN_BIT = 0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ         = 10_000_000;
   localparam int TICK_S         = 1;
   localparam int TICK_CYCLES    = CLK_HZ * TICK_S;
   localparam int TIMEOUT_MIN    = 30;
   localparam int TIMEOUT_TICKS  = TIMEOUT_MIN * 60 / TICK_S;
   localparam int TMR_W          = 12;

   // ----------------------------------------------------------------
   // request classes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CLS_READ,
      CLS_SETTING,
      CLS_COMMAND,
      CLS_COIL
   } req_class_t;

   function automatic logic [31:0] encrypt_pw(input logic [31:0] pw);
      encrypt_pw = (pw == PW_RESET) ? 32'h0000_0000 : ({pw[15:0], pw[31:16]} ^ ENC_KEY);
   endfunction
endpackage

// File: core/inactivity_timer.sv
// one access level on one path: grant flag plus inactivity countdown
// assumes tick is a one-cycle pulse from the core's second divider
module inactivity_timer #(
   parameter int TIMEOUT = pw_gate_pkg::TIMEOUT_TICKS
) (
   input  wire logic ref_clk,
   input  wire logic reset_n,
   input  wire logic tick,
   input  wire logic start,
   input  wire logic restart,
   input  wire logic clear,
   output logic      granted_q
);
   import pw_gate_pkg::*;

   localparam logic [TMR_W-1:0] LOAD = TMR_W'(TIMEOUT);

   logic [TMR_W-1:0] cnt_q;

   // ----------------------------------------------------------------
   // grant and countdown
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         granted_q <= 1'b0;
         cnt_q     <= '0;
      end else if (clear) begin
         granted_q <= 1'b0;
         cnt_q     <= '0;
      end else if (start || (restart && granted_q)) begin
         granted_q <= 1'b1;
         cnt_q     <= LOAD;
      end else if (tick && granted_q) begin
         cnt_q <= cnt_q - TMR_W'(1);
         if (cnt_q == TMR_W'(1)) begin
            granted_q <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_start_loads: assert property (start && !clear |=> granted_q && cnt_q == LOAD)
      else $error("grant not loaded on start");
   a_expiry_drops: assert property (granted_q && tick && cnt_q == TMR_W'(1) && !start
                                    && !restart && !clear |=> !granted_q)
      else $error("grant kept after timeout");
   a_clear_wins: assert property (clear |=> !granted_q)
      else $error("grant survived clear");
   a_restart_reloads: assert property (restart && granted_q && !clear
         |=> granted_q && cnt_q == LOAD)
      else $error("grant not reloaded on use");
endmodule

// File: core/modbus_password_access_gate.sv
// password access gate in front of the relay's modbus register map
// assumes one decoded register access per cycle, tagged with its path index
//
// Notes on behaviour
// - command password at 4000, setting password at 4002, both writable
// - a zero command password removes command protection
// - reading a password returns its encrypted form, zero when unset
// - command password changes only with command access on that path
// - passwords shared with the front panel, either side enables both
// - setting writes need matching setting password or a zero one
// - each level has its own thirty-minute timer started on entry
// - setting writes restart setting timer, command or coil writes command timer
// - register 4010 reads command password enabled state
// - register 4011 reads setting password enabled state
// - access granted only to the path that entered the password
// - tcp disconnect withdraws access on that connection
module modbus_password_access_gate
#(
   parameter int NUM_PATHS    = 4,
   parameter int SEC_CYCLES   = pw_gate_pkg::TICK_CYCLES,
   parameter int TIMEOUT_SECS = pw_gate_pkg::TIMEOUT_TICKS
) (
   input  wire logic                         ref_clk,
   input  wire logic                         reset_n,
   input  wire logic                         req_valid,
   input  wire logic                         req_write,
   input  wire pw_gate_pkg::req_class_t      req_class,
   input  wire logic [15:0]                  req_addr,
   input  wire logic [pw_gate_pkg::REG_W-1:0] req_wdata,
   input  wire logic [$clog2(NUM_PATHS)-1:0] req_path,
   input  wire logic [NUM_PATHS-1:0]         path_disconnect,
   input  wire logic                         panel_pw_wr,
   input  wire logic                         panel_pw_sel,
   input  wire logic [pw_gate_pkg::PW_W-1:0] panel_pw_data,
   output logic                              rsp_valid_q,
   output logic                              rsp_allowed_q,
   output logic [pw_gate_pkg::REG_W-1:0]     rsp_rdata_q,
   output logic                              cmd_pw_enabled_q,
   output logic                              set_pw_enabled_q,
   output logic [NUM_PATHS-1:0]              cmd_grant_q,
   output logic [NUM_PATHS-1:0]              set_grant_q
);
   import pw_gate_pkg::*;

   localparam int DIV_W = $clog2(SEC_CYCLES + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SEC_CYCLES - 1);

   // ----------------------------------------------------------------
   // request decode
   // ----------------------------------------------------------------
   logic            wr;
   logic            rd;
   logic [PW_W-1:0] full_word;
   logic [REG_W-1:0] stage_q;
   logic [PW_W-1:0] cmd_pw_q;
   logic [PW_W-1:0] set_pw_q;
   logic            cmd_ok;
   logic            set_ok;
   logic            is_pw_addr;
   logic            wr_allowed;
   logic            cmd_entry_ok;
   logic            set_entry_ok;
   logic [NUM_PATHS-1:0] path_sel;
   logic [NUM_PATHS-1:0] cmd_start;
   logic [NUM_PATHS-1:0] set_start;
   logic [NUM_PATHS-1:0] cmd_use;
   logic [NUM_PATHS-1:0] set_use;
   logic [DIV_W-1:0] div_q;
   logic            tick_q;
   logic [PW_W-1:0] cmd_enc;
   logic [PW_W-1:0] set_enc;

   assign wr        = req_valid && req_write;
   assign rd        = req_valid && !req_write;
   assign full_word = {stage_q, req_wdata};
   assign path_sel  = NUM_PATHS'(1) << req_path;
   assign cmd_ok    = cmd_grant_q[req_path] || (cmd_pw_q == PW_RESET);
   assign set_ok    = set_grant_q[req_path] || (set_pw_q == PW_RESET);
   assign is_pw_addr = (req_addr[15:4] == CMD_PW_HI_ADDR[15:4]) && (req_addr[3:0] <= 4'hb);
   assign cmd_enc   = encrypt_pw(cmd_pw_q);
   assign set_enc   = encrypt_pw(set_pw_q);

   // entry compares the staged high word with the low word just written
   assign cmd_entry_ok = wr && req_addr == CMD_ENT_LO_ADDR
                         && (full_word == cmd_pw_q || cmd_pw_q == PW_RESET);
   assign set_entry_ok = wr && req_addr == SET_ENT_LO_ADDR
                         && (full_word == set_pw_q || set_pw_q == PW_RESET);

   always_comb begin
      wr_allowed = 1'b1;
      if (req_addr == CMD_PW_HI_ADDR || req_addr == CMD_PW_LO_ADDR) begin
         wr_allowed = cmd_ok;
      end else if (req_addr == SET_PW_HI_ADDR || req_addr == SET_PW_LO_ADDR) begin
         wr_allowed = set_ok;
      end else if (is_pw_addr) begin
         wr_allowed = 1'b1;
      end else begin
         unique case (req_class)
            CLS_READ:    wr_allowed = 1'b1;
            CLS_SETTING: wr_allowed = set_ok;
            CLS_COMMAND: wr_allowed = cmd_ok;
            CLS_COIL:    wr_allowed = cmd_ok;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // per-path timer control
   // ----------------------------------------------------------------
   always_comb begin
      cmd_start = cmd_entry_ok ? path_sel : '0;
      set_start = set_entry_ok ? path_sel : '0;
      cmd_use   = '0;
      set_use   = '0;
      if (wr && wr_allowed && !is_pw_addr) begin
         if (req_class == CLS_SETTING) begin
            set_use = path_sel;
         end
         if (req_class == CLS_COMMAND || req_class == CLS_COIL) begin
            cmd_use = path_sel;
         end
      end
      if (wr && wr_allowed && (req_addr == SET_PW_LO_ADDR)) begin
         set_use = path_sel;
      end
   end

   // ----------------------------------------------------------------
   // one-second tick divider
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (div_q == DIV_LAST);
         div_q  <= (div_q == DIV_LAST) ? '0 : div_q + DIV_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // level timers, one pair per path
   // ----------------------------------------------------------------
   for (genvar p = 0; p < NUM_PATHS; p++) begin : g_path
      inactivity_timer #(.TIMEOUT(TIMEOUT_SECS)) u_cmd_tmr (
         .ref_clk   (ref_clk),
         .reset_n   (reset_n),
         .tick      (tick_q),
         .start     (cmd_start[p]),
         .restart   (cmd_use[p]),
         .clear     (path_disconnect[p]),
         .granted_q (cmd_grant_q[p])
      );
      inactivity_timer #(.TIMEOUT(TIMEOUT_SECS)) u_set_tmr (
         .ref_clk   (ref_clk),
         .reset_n   (reset_n),
         .tick      (tick_q),
         .start     (set_start[p]),
         .restart   (set_use[p]),
         .clear     (path_disconnect[p]),
         .granted_q (set_grant_q[p])
      );
   end

   // ----------------------------------------------------------------
   // high-word staging for 32-bit registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         stage_q <= '0;
      end else if (wr && !req_addr[0] && is_pw_addr) begin
         stage_q <= req_wdata;
      end
   end

   // ----------------------------------------------------------------
   // password settings, shared with the front panel
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cmd_pw_q <= PW_RESET;
         set_pw_q <= PW_RESET;
      end else if (panel_pw_wr) begin
         if (panel_pw_sel) begin
            set_pw_q <= panel_pw_data;
         end else begin
            cmd_pw_q <= panel_pw_data;
         end
      end else if (wr && wr_allowed) begin
         if (req_addr == CMD_PW_LO_ADDR) begin
            cmd_pw_q <= full_word;
         end
         if (req_addr == SET_PW_LO_ADDR) begin
            set_pw_q <= full_word;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cmd_pw_enabled_q <= 1'b0;
         set_pw_enabled_q <= 1'b0;
      end else begin
         cmd_pw_enabled_q <= (cmd_pw_q != PW_RESET);
         set_pw_enabled_q <= (set_pw_q != PW_RESET);
      end
   end

   // ----------------------------------------------------------------
   // response
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rsp_valid_q   <= 1'b0;
         rsp_allowed_q <= 1'b0;
         rsp_rdata_q   <= '0;
      end else begin
         rsp_valid_q   <= req_valid;
         rsp_allowed_q <= req_valid && (!req_write || wr_allowed);
         rsp_rdata_q   <= '0;
         if (rd) begin
            unique case (req_addr)
               CMD_PW_HI_ADDR: rsp_rdata_q <= cmd_enc[31:16];
               CMD_PW_LO_ADDR: rsp_rdata_q <= cmd_enc[15:0];
               SET_PW_HI_ADDR: rsp_rdata_q <= set_enc[31:16];
               SET_PW_LO_ADDR: rsp_rdata_q <= set_enc[15:0];
               CMD_STAT_ADDR:  rsp_rdata_q[STAT_EN_BIT] <= (cmd_pw_q != PW_RESET);
               SET_STAT_ADDR:  rsp_rdata_q[STAT_EN_BIT] <= (set_pw_q != PW_RESET);
               default:        rsp_rdata_q <= '0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence s_panel_cmd;
      panel_pw_wr && !panel_pw_sel ##1 !panel_pw_wr && !(wr && req_addr == CMD_PW_LO_ADDR);
   endsequence

   a_panel_shares_enable: assert property (s_panel_cmd |=>
         cmd_pw_enabled_q == ($past(panel_pw_data, 2) != PW_RESET))
      else $error("panel password not reflected in enable");
   a_cmd_pw_guard: assert property (wr && req_addr == CMD_PW_LO_ADDR && !cmd_ok
         && !panel_pw_wr |=> $stable(cmd_pw_q) && !rsp_allowed_q)
      else $error("command password changed without access");
   a_cmd_pw_store: assert property (wr && req_addr == CMD_PW_LO_ADDR && cmd_ok
         && !panel_pw_wr |=> cmd_pw_q == $past(full_word))
      else $error("command password not stored");
   a_zero_unlocks: assert property (wr && req_class == CLS_COIL && !is_pw_addr
         && cmd_pw_q == PW_RESET |=> rsp_allowed_q)
      else $error("coil refused with no command password");
   a_setting_locked: assert property (wr && req_class == CLS_SETTING && !is_pw_addr
         && !set_grant_q[req_path] && set_pw_q != PW_RESET |=> !rsp_allowed_q)
      else $error("setting write allowed without access");
   a_read_encrypted: assert property (rd && req_addr == CMD_PW_LO_ADDR
         |=> rsp_rdata_q == $past(cmd_enc[15:0]))
      else $error("password read not encrypted");
   a_cmd_status: assert property (rd && req_addr == CMD_STAT_ADDR
         |=> rsp_rdata_q == {15'h0000, $past(cmd_pw_q != PW_RESET)})
      else $error("command status wrong");
   a_set_status: assert property (rd && req_addr == SET_STAT_ADDR
         |=> rsp_rdata_q == {15'h0000, $past(set_pw_q != PW_RESET)})
      else $error("setting status wrong");
   a_grant_own_path: assert property (cmd_entry_ok && !path_disconnect[req_path]
         |=> cmd_grant_q[$past(req_path)]
             && ((cmd_grant_q & ~$past(cmd_grant_q) & ~$past(path_sel)) == '0))
      else $error("command grant not confined to entering path");
   a_disconnect_revokes: assert property (path_disconnect != '0
         |=> ((cmd_grant_q | set_grant_q) & $past(path_disconnect)) == '0)
      else $error("grant survived disconnect");
   a_rsp_timing: assert property (req_valid |=> rsp_valid_q ##1 (rsp_valid_q == $past(req_valid)))
      else $error("response not one cycle after request");
   a_set_pw_guard: assert property (wr && req_addr == SET_PW_LO_ADDR && !set_ok
         && !panel_pw_wr |=> $stable(set_pw_q) && !rsp_allowed_q)
      else $error("setting password changed without access");
   a_cmd_locked: assert property (wr && req_class inside {CLS_COMMAND, CLS_COIL}
         && !is_pw_addr && !cmd_grant_q[req_path] && cmd_pw_q != PW_RESET |=> !rsp_allowed_q)
      else $error("command write allowed without access");
   a_set_grant_own: assert property (set_entry_ok && !path_disconnect[req_path]
         |=> set_grant_q[$past(req_path)]
             && ((set_grant_q & ~$past(set_grant_q) & ~$past(path_sel)) == '0))
      else $error("setting grant not confined to entering path");
   a_read_allowed: assert property (rd |=> rsp_valid_q && rsp_allowed_q)
      else $error("read refused");
   a_write_no_data: assert property (wr |=> rsp_rdata_q == '0)
      else $error("write returned data");
   a_stage_high: assert property (wr && !req_addr[0] && is_pw_addr
         |=> stage_q == $past(req_wdata))
      else $error("high word not staged");
   a_cmd_enable_track: assert property (1'b1
         |=> cmd_pw_enabled_q == ($past(cmd_pw_q) != PW_RESET))
      else $error("command enable does not follow password");
   a_set_enable_track: assert property (1'b1
         |=> set_pw_enabled_q == ($past(set_pw_q) != PW_RESET))
      else $error("setting enable does not follow password");
endmodule

// File: bench/modbus_master_model.sv
// modbus master model: one register access at a time on a chosen path
// assumes the gate answers with rsp_valid_q one cycle after each access
module modbus_master_model
   import pw_gate_pkg::*;
#(
   parameter int NUM_PATHS = 4
) (
   input  wire logic                          ref_clk,
   input  wire logic                          rsp_valid_q,
   input  wire logic                          rsp_allowed_q,
   input  wire logic [pw_gate_pkg::REG_W-1:0] rsp_rdata_q,
   output logic                               req_valid,
   output logic                               req_write,
   output pw_gate_pkg::req_class_t            req_class,
   output logic [15:0]                        req_addr,
   output logic [pw_gate_pkg::REG_W-1:0]      req_wdata,
   output logic [$clog2(NUM_PATHS)-1:0]       req_path
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PATH_W = $clog2(NUM_PATHS);
   logic        rsp_ok;
   logic [15:0] rsp_data;
   initial begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_class = CLS_READ;
      req_addr  = 16'h0000;
      req_wdata = 16'h0000;
      req_path  = '0;
   end
   // ----------------------------------------------------------------
   // single access, answer taken one cycle later
   // ----------------------------------------------------------------
   task automatic acc(input logic [PATH_W-1:0] p, input logic w, input req_class_t c,
                      input logic [15:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      req_valid = 1'b1;
      req_write = w;
      req_class = c;
      req_addr  = a;
      req_wdata = d;
      req_path  = p;
      @(posedge ref_clk);
      @(negedge ref_clk);
      rsp_ok    = rsp_valid_q ? rsp_allowed_q : 1'bx;
      rsp_data  = rsp_valid_q ? rsp_rdata_q : 16'hxxxx;
      // released bus shows a changed value
      req_valid = 1'b0;
      req_addr  = ~req_addr;
      req_wdata = ~req_wdata;
   endtask
   // high word first, then low word
   task automatic wr32(input logic [PATH_W-1:0] p, input logic [15:0] a, input logic [31:0] v);
      acc(p, 1'b1, CLS_READ, a, v[31:16]);
      acc(p, 1'b1, CLS_READ, a + 16'h0001, v[15:0]);
   endtask
   // password entry on the path that wants access
   task automatic enter(input logic [PATH_W-1:0] p, input logic lvl, input logic [31:0] v);
      wr32(p, lvl ? SET_ENT_HI_ADDR : CMD_ENT_HI_ADDR, v);
   endtask
endmodule

// File: bench/tb_top.sv
// self-checking bench for the password access gate
// assumes short timer parameters: 10 cycles a second, 5 seconds timeout
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pw_gate_pkg::*;
   logic ref_clk, reset_n, req_valid, req_write, panel_pw_wr, panel_pw_sel;
   logic rsp_valid_q, rsp_allowed_q, cmd_pw_enabled_q, set_pw_enabled_q;
   req_class_t req_class;
   logic [15:0] req_addr, req_wdata, rsp_rdata_q;
   logic [1:0]  req_path;
   logic [3:0]  path_disconnect, cmd_grant_q, set_grant_q;
   logic [31:0] panel_pw_data;
   int          err_count = 0;
   int          num_checks = 0;
   modbus_password_access_gate #(.NUM_PATHS(4), .SEC_CYCLES(10), .TIMEOUT_SECS(5))
   modbus_password_access_gate_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .req_valid(req_valid), .req_write(req_write), .req_class(req_class),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_path(req_path),
      .path_disconnect(path_disconnect), .panel_pw_wr(panel_pw_wr),
      .panel_pw_sel(panel_pw_sel), .panel_pw_data(panel_pw_data),
      .rsp_valid_q(rsp_valid_q), .rsp_allowed_q(rsp_allowed_q), .rsp_rdata_q(rsp_rdata_q),
      .cmd_pw_enabled_q(cmd_pw_enabled_q), .set_pw_enabled_q(set_pw_enabled_q),
      .cmd_grant_q(cmd_grant_q), .set_grant_q(set_grant_q));
   modbus_master_model #(.NUM_PATHS(4)) modbus_master_model_inst (.ref_clk(ref_clk),
      .rsp_valid_q(rsp_valid_q), .rsp_allowed_q(rsp_allowed_q), .rsp_rdata_q(rsp_rdata_q),
      .req_valid(req_valid), .req_write(req_write), .req_class(req_class),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_path(req_path));
   // ----------------------------------------------------------------
   // clock, checks, shared access tasks
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic give_verdict();
      if (err_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic rd(input logic [1:0] p, input logic [15:0] a, input logic [15:0] e,
                     input string msg);
      modbus_master_model_inst.acc(p, 1'b0, CLS_READ, a, 16'h0000);
      chk(modbus_master_model_inst.rsp_data, e, msg);
      chk({15'h0000, modbus_master_model_inst.rsp_ok}, 16'h0001, msg);
   endtask
   task automatic op(input logic [1:0] p, input req_class_t c, input logic e, input string msg);
      modbus_master_model_inst.acc(p, 1'b1, c, 16'h1000, 16'h0001);
      chk({15'h0000, modbus_master_model_inst.rsp_ok}, {15'h0000, e}, msg);
   endtask
   task automatic panel(input logic sel, input logic [31:0] v);
      @(negedge ref_clk);
      panel_pw_wr   = 1'b1;
      panel_pw_sel  = sel;
      panel_pw_data = v;
      @(negedge ref_clk);
      panel_pw_wr   = 1'b0;
      idle(2);
   endtask
   initial begin
      #200_000;
      err_count++;
      give_verdict();
   end
   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      reset_n         = 1'b0;
      panel_pw_wr     = 1'b0;
      panel_pw_sel    = 1'b0;
      panel_pw_data   = 32'h0000_0000;
      path_disconnect = 4'h0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      reset_n = 1'b1;
      rd(0, CMD_STAT_ADDR, 16'h0000, "cmd status after reset");
      rd(1, SET_STAT_ADDR, 16'h0000, "set status after reset");
      rd(0, CMD_PW_HI_ADDR, 16'h0000, "unset cmd pw read");
      op(1, CLS_COMMAND, 1'b1, "command with zero pw");
      modbus_master_model_inst.wr32(0, CMD_PW_HI_ADDR, 32'h0001_0002);
      chk({15'h0000, modbus_master_model_inst.rsp_ok}, 16'h0001, "cmd pw store");
      idle(2);
      rd(0, CMD_STAT_ADDR, 16'h0001, "cmd status enabled");
      rd(0, CMD_PW_HI_ADDR, 16'h5a3e, "cmd pw high encrypted");
      rd(0, CMD_PW_LO_ADDR, 16'h96e0, "cmd pw low encrypted");
      op(0, CLS_COMMAND, 1'b0, "command without entry");
      modbus_master_model_inst.wr32(0, CMD_PW_HI_ADDR, 32'h0000_0000);
      chk({15'h0000, modbus_master_model_inst.rsp_ok}, 16'h0000, "cmd pw change denied");
      idle(2);
      rd(0, CMD_STAT_ADDR, 16'h0001, "cmd pw kept");
      modbus_master_model_inst.enter(0, 1'b0, 32'h0001_0003);
      idle(2);
      chk({12'h000, cmd_grant_q}, 16'h0000, "wrong entry");
      modbus_master_model_inst.enter(0, 1'b0, 32'h0001_0002);
      idle(2);
      chk({12'h000, cmd_grant_q}, 16'h0001, "cmd grant on path 0");
      op(1, CLS_COMMAND, 1'b0, "command on other path");
      op(0, CLS_COIL, 1'b1, "coil with grant");
      idle(36);
      chk({12'h000, cmd_grant_q}, 16'h0001, "grant before timeout");
      op(0, CLS_COMMAND, 1'b1, "command after coil restart");
      idle(36);
      chk({12'h000, cmd_grant_q}, 16'h0001, "grant after command restart");
      idle(20);
      chk({12'h000, cmd_grant_q}, 16'h0000, "grant after timeout");
      op(0, CLS_COMMAND, 1'b0, "command after timeout");
      panel(1'b1, 32'h0000_1234);
      rd(2, SET_STAT_ADDR, 16'h0001, "panel set pw seen on bus");
      chk({15'h0000, set_pw_enabled_q}, 16'h0001, "set pw enabled flag");
      rd(2, SET_PW_LO_ADDR, 16'h96e1, "set pw low encrypted");
      op(2, CLS_SETTING, 1'b0, "setting without entry");
      modbus_master_model_inst.enter(2, 1'b1, 32'h0000_1234);
      idle(2);
      chk({12'h000, set_grant_q}, 16'h0004, "set grant on path 2");
      op(2, CLS_SETTING, 1'b1, "setting with grant");
      op(3, CLS_SETTING, 1'b0, "setting on other path");
      @(negedge ref_clk);
      path_disconnect = 4'h4;
      @(negedge ref_clk);
      path_disconnect = 4'h0;
      idle(2);
      chk({12'h000, set_grant_q}, 16'h0000, "grant after disconnect");
      op(2, CLS_SETTING, 1'b0, "setting after disconnect");
      modbus_master_model_inst.enter(2, 1'b1, 32'h0000_1234);
      modbus_master_model_inst.wr32(2, SET_PW_HI_ADDR, 32'h0000_0000);
      idle(2);
      rd(2, SET_STAT_ADDR, 16'h0000, "set pw cleared");
      chk({15'h0000, set_pw_enabled_q}, 16'h0000, "set pw disabled flag");
      op(3, CLS_SETTING, 1'b1, "setting with zero pw");
      modbus_master_model_inst.enter(0, 1'b0, 32'h0001_0002);
      modbus_master_model_inst.wr32(0, CMD_PW_HI_ADDR, 32'h0000_0000);
      idle(2);
      chk({15'h0000, cmd_pw_enabled_q}, 16'h0000, "cmd pw removed");
      op(3, CLS_COMMAND, 1'b1, "command after pw removed");
      panel(1'b0, 32'h0001_0002);
      chk({15'h0000, cmd_pw_enabled_q}, 16'h0001, "panel cmd pw enabled");
      op(3, CLS_COMMAND, 1'b0, "command after panel pw");
      @(negedge ref_clk);
      reset_n = 1'b0;
      idle(2);
      reset_n = 1'b1;
      rd(3, CMD_STAT_ADDR, 16'h0000, "cmd status after second reset");
      give_verdict();
   end
endmodule
